// *** rtl/bridge_hdr_pkg.sv ***
/*
 * Constants for the bridge header register bank: register indices,
 * field positions, reset and fixed values.
 * Assumes an APB slave with 32-bit data, one register per word.
 */
package bridge_hdr_pkg;

    localparam int unsigned APB_AW  = 8;
    localparam int unsigned APB_DW  = 32;
    localparam int unsigned IO_AW   = 32;

    // register index; byte address is four times the index
    localparam logic [7:0] IDX_HEADER_TYPE  = 8'h0E;
    localparam logic [7:0] IDX_SELF_TEST    = 8'h0F;
    localparam logic [7:0] IDX_BASE_ADDR_0  = 8'h10;
    localparam logic [7:0] IDX_BASE_ADDR_1  = 8'h14;
    localparam logic [7:0] IDX_PRIMARY_BUS  = 8'h18;
    localparam logic [7:0] IDX_SECOND_BUS   = 8'h19;
    localparam logic [7:0] IDX_SUBORD_BUS   = 8'h1A;
    localparam logic [7:0] IDX_SEC_LATENCY  = 8'h1B;
    localparam logic [7:0] IDX_IO_BASE      = 8'h1C;
    localparam logic [7:0] IDX_IO_LIMIT     = 8'h1D;
    localparam logic [7:0] IDX_SEC_STATUS   = 8'h1E;

    localparam logic [7:0]  HEADER_TYPE_VAL = 8'h01;
    localparam logic [7:0]  SELF_TEST_VAL   = 8'h00;
    localparam logic [31:0] BASE_ADDR_VAL   = 32'h0000_0000;
    localparam logic [7:0]  SEC_LATENCY_VAL = 8'h00;
    localparam logic [7:0]  BUS_NUM_RST     = 8'h00;

    localparam logic        IO_WIDTH_16     = 1'b0;
    localparam logic        IO_WIDTH_32     = 1'b1;
    localparam logic        IO_CAP_RST      = IO_WIDTH_32;
    localparam logic [3:0]  IO_BASE_RST     = 4'hF;
    localparam logic [3:0]  IO_LIMIT_RST    = 4'h0;
    localparam logic [11:0] IO_LOW_ZEROS    = 12'h000;
    localparam logic [11:0] IO_LOW_ONES     = 12'hFFF;

    localparam int unsigned IO_CAP_BIT      = 0;
    localparam int unsigned IO_FIELD_LSB    = 4;
    localparam int unsigned IO_FIELD_MSB    = 7;
    localparam int unsigned STS_MDP_BIT     = 8;
    localparam int unsigned STS_SYS_ERR_BIT = 14;
    localparam int unsigned STS_PAR_ERR_BIT = 15;
    localparam int unsigned LANE0           = 0;
    localparam int unsigned LANE1           = 1;

    function automatic logic [APB_AW-1:0] reg_addr
    (
        input logic [7:0] idx
    );
        return {idx[5:0], 2'b00};
    endfunction : reg_addr

endpackage : bridge_hdr_pkg

// *** rtl/io_window_match.sv ***
/*
 * I/O forwarding window compare: base and limit fields give
 * address bits 15:12, low twelve bits are zeros and ones.
 * Assumes upper halves come from the port when 32-bit I/O is on.
 */
`timescale 1ns/10ps
`default_nettype none
module io_window_match
    import bridge_hdr_pkg::*;
(
    input  wire logic [IO_AW-1:0] addr,
    input  wire logic [3:0]       win_low,
    input  wire logic [3:0]       win_high,
    input  wire logic             width_cap,
    input  wire logic [15:0]      upper_low,
    input  wire logic [15:0]      upper_high,
    output logic                  hit
);
    logic [IO_AW-1:0] lo_addr;
    logic [IO_AW-1:0] hi_addr;
    logic [15:0]      up_lo;
    logic [15:0]      up_hi;

    always_comb
    begin
        // 16-bit mode: the upper half of the window is zero
        up_lo = (width_cap == IO_WIDTH_32) ? upper_low : 16'h0000;
        up_hi = (width_cap == IO_WIDTH_32) ? upper_high : 16'h0000;
        lo_addr = {up_lo, win_low, IO_LOW_ZEROS};
        hi_addr = {up_hi, win_high, IO_LOW_ONES};
        hit = (addr >= lo_addr) && (addr <= hi_addr); // RULE_12
    end

endmodule : io_window_match
`default_nettype wire

// *** rtl/bridge_hdr_regs.sv ***
/*
 * Bridge header register bank (header type through secondary status)
 * as an APB slave, with the I/O forwarding window decision.
 * Assumes enables and error events come from port logic on pclk.
 */
// How it works
// RULE_01: header type reads fixed 0x01, a single-function type 1 layout.
// RULE_02: self-test byte is read-only and shows no self-test support.
// RULE_03: both base address registers read zero and ignore writes.
// RULE_04: primary bus number is 8-bit read-write, resets to zero.
// RULE_05: secondary bus number is 8-bit read-write, resets to zero.
// RULE_06: subordinate bus number is 8-bit read-write, resets to zero.
// RULE_07: secondary latency timer byte reads zero.
// RULE_08: I/O base bit 0 holds width capability, reset 1 (32-bit).
// RULE_09: I/O limit bit 0 always mirrors the width capability bit.
// RULE_10: I/O base bits 7:4, reset 0xF, give window low address 15:12.
// RULE_11: I/O limit bits 7:4, reset 0, give high address, low bits ones.
// RULE_12: I/O requests are forwarded when inside the base-limit window.
// RULE_13: status bit 8 sets on poisoned secondary traffic with parity on.
// RULE_14: status bits 9 to 13 read zero.
// RULE_15: status bit 14 sets on error message only with system error on.
// RULE_16: status bit 15 sets on any poisoned TLP on the secondary side.
// RULE_17: upstream port also sets bit 15 on internal parity error.
// RULE_18: writing one clears a status bit; zero keeps; reserved reads 0.
// RULE_19: writes to read-only fields are ignored.
`timescale 1ns/10ps
`default_nettype none
module bridge_hdr_regs
    import bridge_hdr_pkg::*;
#(
    parameter bit IS_UPSTREAM = 1'b1
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [APB_DW-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [APB_DW-1:0]      prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              parity_response_enable,
    input  wire logic              system_error_enable,
    input  wire logic              sec_poisoned_cpl_rx,
    input  wire logic              sec_poisoned_wr_tx,
    input  wire logic              sec_err_msg_rx,
    input  wire logic              sec_poisoned_tlp_rx,
    input  wire logic              switch_parity_err,
    input  wire logic              io_req_valid,
    input  wire logic [IO_AW-1:0]  io_req_addr,
    input  wire logic [15:0]       io_upper_low,
    input  wire logic [15:0]       io_upper_high,
    output logic                   io_fwd_valid,
    output logic                   io_fwd_hit,
    output logic [7:0]             primary_bus_num,
    output logic [7:0]             secondary_bus_num,
    output logic [7:0]             subordinate_bus_num,
    output logic                   io_width_capability
);

    typedef struct packed {
        logic [APB_DW-1:0] rdata;
        logic              slverr;
        logic [7:0]        pbus;
        logic [7:0]        sbus;
        logic [7:0]        subbus;
        logic              io_cap;
        logic [3:0]        io_low;
        logic [3:0]        io_high;
        logic              mdp;
        logic              sys_err;
        logic              par_err;
        logic              fwd_valid;
        logic              fwd_hit;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    logic setup_rd;
    logic wr_acc;
    logic win_hit;
    logic set_mdp;
    logic set_sys_err;
    logic set_par_err;
    logic clr_mdp;
    logic clr_sys_err;
    logic clr_par_err;
    logic wr_status;

    // true when the address hits one of the bank's words
    function automatic logic is_mapped
    (
        input logic [APB_AW-1:0] a
    );
        return (a == reg_addr(IDX_HEADER_TYPE)) ||
               (a == reg_addr(IDX_SELF_TEST))   ||
               (a == reg_addr(IDX_BASE_ADDR_0)) ||
               (a == reg_addr(IDX_BASE_ADDR_1)) ||
               (a == reg_addr(IDX_PRIMARY_BUS)) ||
               (a == reg_addr(IDX_SECOND_BUS))  ||
               (a == reg_addr(IDX_SUBORD_BUS))  ||
               (a == reg_addr(IDX_SEC_LATENCY)) ||
               (a == reg_addr(IDX_IO_BASE))     ||
               (a == reg_addr(IDX_IO_LIMIT))    ||
               (a == reg_addr(IDX_SEC_STATUS));
    endfunction : is_mapped

    // byte write to one register word on lane 0
    function automatic logic wr_byte
    (
        input logic              acc,
        input logic [APB_AW-1:0] a,
        input logic [7:0]        idx,
        input logic [3:0]        strb
    );
        return acc && (a == reg_addr(idx)) && strb[LANE0];
    endfunction : wr_byte

    function automatic logic [APB_DW-1:0] read_word
    (
        input logic [APB_AW-1:0] a,
        input state_t            s
    );
        logic [APB_DW-1:0] d;
        d = '0; // RULE_14
        unique case (a)
            reg_addr(IDX_HEADER_TYPE):
                d[7:0] = HEADER_TYPE_VAL; // RULE_01
            reg_addr(IDX_SELF_TEST):
                d[7:0] = SELF_TEST_VAL; // RULE_02
            reg_addr(IDX_BASE_ADDR_0):
                d = BASE_ADDR_VAL; // RULE_03
            reg_addr(IDX_BASE_ADDR_1):
                d = BASE_ADDR_VAL; // RULE_03
            reg_addr(IDX_PRIMARY_BUS):
                d[7:0] = s.pbus;
            reg_addr(IDX_SECOND_BUS):
                d[7:0] = s.sbus;
            reg_addr(IDX_SUBORD_BUS):
                d[7:0] = s.subbus;
            reg_addr(IDX_SEC_LATENCY):
                d[7:0] = SEC_LATENCY_VAL; // RULE_07
            reg_addr(IDX_IO_BASE):
            begin
                d[IO_CAP_BIT] = s.io_cap;
                d[IO_FIELD_MSB:IO_FIELD_LSB] = s.io_low;
            end
            reg_addr(IDX_IO_LIMIT):
            begin
                d[IO_CAP_BIT] = s.io_cap; // RULE_09
                d[IO_FIELD_MSB:IO_FIELD_LSB] = s.io_high;
            end
            reg_addr(IDX_SEC_STATUS):
            begin
                // bits 13:9 and 7:0 stay zero
                d[STS_MDP_BIT] = s.mdp; // RULE_13
                d[STS_SYS_ERR_BIT] = s.sys_err;
                d[STS_PAR_ERR_BIT] = s.par_err;
            end
            default:
                d = '0;
        endcase
        return d;
    endfunction : read_word

    io_window_match u_io_window
    (
        .addr       (io_req_addr),
        .win_low    (st_r.io_low),
        .win_high   (st_r.io_high),
        .width_cap  (st_r.io_cap),
        .upper_low  (io_upper_low),
        .upper_high (io_upper_high),
        .hit        (win_hit)
    );

    // zero-wait slave: read data is captured in the setup cycle
    assign pready   = 1'b1;
    assign setup_rd = psel && !penable;
    assign wr_acc   = psel && penable && pwrite && pready;

    assign wr_status = wr_acc && (paddr == reg_addr(IDX_SEC_STATUS)) &&
                       pstrb[LANE1];

    assign set_mdp = parity_response_enable &&
                     (sec_poisoned_cpl_rx || sec_poisoned_wr_tx); // RULE_13
    assign set_sys_err = system_error_enable && sec_err_msg_rx; // RULE_15
    assign set_par_err = sec_poisoned_tlp_rx || // RULE_16
                         (IS_UPSTREAM && switch_parity_err); // RULE_17

    assign clr_mdp = wr_status && pwdata[STS_MDP_BIT]; // RULE_18
    assign clr_sys_err = wr_status && pwdata[STS_SYS_ERR_BIT]; // RULE_18
    assign clr_par_err = wr_status && pwdata[STS_PAR_ERR_BIT]; // RULE_18

    always_comb
    begin
        st_nxt = st_r;
        if (setup_rd)
        begin
            st_nxt.rdata  = pwrite ? '0 : read_word(paddr, st_r);
            st_nxt.slverr = !is_mapped(paddr);
        end
        // read-only words fall through with no effect
        if (wr_byte(wr_acc, paddr, IDX_PRIMARY_BUS, pstrb)) // RULE_19
        begin
            st_nxt.pbus = pwdata[7:0]; // RULE_04
        end
        if (wr_byte(wr_acc, paddr, IDX_SECOND_BUS, pstrb))
        begin
            st_nxt.sbus = pwdata[7:0]; // RULE_05
        end
        if (wr_byte(wr_acc, paddr, IDX_SUBORD_BUS, pstrb))
        begin
            st_nxt.subbus = pwdata[7:0]; // RULE_06
        end
        if (wr_byte(wr_acc, paddr, IDX_IO_BASE, pstrb))
        begin
            st_nxt.io_cap = pwdata[IO_CAP_BIT]; // RULE_08
            st_nxt.io_low = pwdata[IO_FIELD_MSB:IO_FIELD_LSB]; // RULE_10
        end
        if (wr_byte(wr_acc, paddr, IDX_IO_LIMIT, pstrb))
        begin
            st_nxt.io_high = pwdata[IO_FIELD_MSB:IO_FIELD_LSB]; // RULE_11
        end
        // a new event wins over a clear in the same cycle
        st_nxt.mdp = (st_r.mdp && !clr_mdp) || set_mdp; // RULE_13
        st_nxt.sys_err = (st_r.sys_err && !clr_sys_err) ||
                         set_sys_err; // RULE_15
        st_nxt.par_err = (st_r.par_err && !clr_par_err) ||
                         set_par_err; // RULE_16
        st_nxt.fwd_valid = io_req_valid;
        st_nxt.fwd_hit   = io_req_valid && win_hit; // RULE_12
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r         <= '0;
            st_r.pbus    <= BUS_NUM_RST;
            st_r.sbus    <= BUS_NUM_RST;
            st_r.subbus  <= BUS_NUM_RST;
            st_r.io_cap  <= IO_CAP_RST;
            st_r.io_low  <= IO_BASE_RST;
            st_r.io_high <= IO_LIMIT_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign prdata              = st_r.rdata;
    assign pslverr             = st_r.slverr && psel && penable;
    assign io_fwd_valid        = st_r.fwd_valid;
    assign io_fwd_hit          = st_r.fwd_hit;
    assign primary_bus_num     = st_r.pbus;
    assign secondary_bus_num   = st_r.sbus;
    assign subordinate_bus_num = st_r.subbus;
    assign io_width_capability = st_r.io_cap;

    logic acc_rd;
    assign acc_rd = psel && penable && !pwrite;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_hdr_fixed_read: assert property ( // RULE_01
        $past(setup_rd) && acc_rd && $stable(paddr) &&
        paddr == reg_addr(IDX_HEADER_TYPE)
        |-> prdata == {24'h000000, HEADER_TYPE_VAL})
        else $error("header type read not 0x01");

    a_self_test_read: assert property ( // RULE_02
        $past(setup_rd) && acc_rd && $stable(paddr) &&
        paddr == reg_addr(IDX_SELF_TEST)
        |-> prdata == {24'h000000, SELF_TEST_VAL})
        else $error("self-test byte read wrong");

    a_bar_zero_read: assert property ( // RULE_03
        $past(setup_rd) && acc_rd && $stable(paddr) &&
        (paddr == reg_addr(IDX_BASE_ADDR_0) ||
         paddr == reg_addr(IDX_BASE_ADDR_1))
        |-> prdata == BASE_ADDR_VAL)
        else $error("base address register not zero");

    a_pbus_write: assert property ( // RULE_04
        wr_acc && pstrb[LANE0] && paddr == reg_addr(IDX_PRIMARY_BUS)
        |=> primary_bus_num == $past(pwdata[7:0]))
        else $error("primary bus number not written");

    a_subbus_hold: assert property ( // RULE_06
        !(wr_acc && paddr == reg_addr(IDX_SUBORD_BUS))
        |=> $stable(subordinate_bus_num))
        else $error("subordinate bus number changed without write");

    a_cap_mirror: assert property ( // RULE_09
        $past(setup_rd) && acc_rd && $stable(paddr) &&
        paddr == reg_addr(IDX_IO_LIMIT) && $stable(st_r.io_cap)
        |-> prdata[IO_CAP_BIT] == io_width_capability)
        else $error("limit capability bit does not mirror base");

    a_mdp_set: assert property ( // RULE_13
        parity_response_enable && sec_poisoned_wr_tx
        |=> st_r.mdp)
        else $error("poisoned write did not set bit 8");

    a_sys_err_gate: assert property ( // RULE_15
        !system_error_enable && !st_r.sys_err |=> !st_r.sys_err)
        else $error("bit 14 set while system error disabled");

    a_par_err_set: assert property ( // RULE_16
        sec_poisoned_tlp_rx |=> st_r.par_err ##1
        (st_r.par_err || $past(clr_par_err)))
        else $error("poisoned TLP did not set bit 15");

    a_w1c_clear: assert property ( // RULE_18
        clr_par_err && !set_par_err |=> !st_r.par_err)
        else $error("write one did not clear bit 15");

    a_window_hit: assert property ( // RULE_12
        io_req_valid && st_r.io_cap == IO_WIDTH_16 &&
        io_req_addr[15:12] >= st_r.io_low &&
        io_req_addr[15:12] <= st_r.io_high &&
        io_req_addr[31:16] == 16'h0000
        |=> io_fwd_valid && io_fwd_hit)
        else $error("in-window I/O address not forwarded");

    a_sbus_write: assert property ( // RULE_05
        wr_acc && pstrb[LANE0] && paddr == reg_addr(IDX_SECOND_BUS)
        |=> secondary_bus_num == $past(pwdata[7:0]))
        else $error("secondary bus number not written");

    a_status_zero: assert property ( // RULE_14
        $past(setup_rd) && acc_rd && $stable(paddr) &&
        paddr == reg_addr(IDX_SEC_STATUS)
        |-> prdata[13:9] == 5'h00 && prdata[7:0] == 8'h00)
        else $error("status reserved bits not zero");

    a_par_err_internal: assert property ( // RULE_17
        IS_UPSTREAM && switch_parity_err |=> st_r.par_err)
        else $error("internal parity error did not set bit 15");

endmodule : bridge_hdr_regs
`default_nettype wire

// *** sim/bridge_type1_header_regs_tb.sv ***
/*
 * Self-checking bench for the bridge header register bank: APB register
 * accesses, status events and I/O forwarding window decisions.
 * Assumes the bank is an APB slave on pclk with upstream parity enabled.
 */
`timescale 1ns/10ps
`default_nettype none
module bridge_type1_header_regs_tb
    import bridge_hdr_pkg::*;
;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
    logic [APB_DW-1:0] prdata;
    logic [3:0]        pstrb;
    logic              pready;
    logic              pslverr;
    logic              perr_en;
    logic              serr_en;
    logic [4:0]        ev;
    logic              io_req_valid;
    logic [IO_AW-1:0]  io_req_addr;
    logic [15:0]       up_lo;
    logic [15:0]       up_hi;
    logic              io_fwd_valid;
    logic              io_fwd_hit;
    logic [7:0]        pbn;
    logic [7:0]        sbn;
    logic [7:0]        subn;
    logic              io_cap;
    logic [31:0]       rd;
    logic              er;
    int                err_count = 0;
    int                checks_done = 0;
    int                cycles = 0;
    logic [7:0]        idx_t [11] = '{IDX_HEADER_TYPE, IDX_SELF_TEST,
        IDX_BASE_ADDR_0, IDX_BASE_ADDR_1, IDX_PRIMARY_BUS, IDX_SECOND_BUS,
        IDX_SUBORD_BUS, IDX_SEC_LATENCY, IDX_IO_BASE, IDX_IO_LIMIT,
        IDX_SEC_STATUS};
    logic [31:0]       rst_v [11] = '{32'h0000_0001, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_00F1, 32'h0000_0001, 32'h0};
    int                ro_i [5] = '{0, 1, 2, 3, 7};

    bridge_hdr_regs #(.IS_UPSTREAM(1'b1)) dut
    (
        .pclk                   (pclk),
        .presetn                (presetn),
        .psel                   (psel),
        .penable                (penable),
        .pwrite                 (pwrite),
        .paddr                  (paddr),
        .pwdata                 (pwdata),
        .pstrb                  (pstrb),
        .prdata                 (prdata),
        .pready                 (pready),
        .pslverr                (pslverr),
        .parity_response_enable (perr_en),
        .system_error_enable    (serr_en),
        .sec_poisoned_cpl_rx    (ev[0]),
        .sec_poisoned_wr_tx     (ev[1]),
        .sec_err_msg_rx         (ev[2]),
        .sec_poisoned_tlp_rx    (ev[3]),
        .switch_parity_err      (ev[4]),
        .io_req_valid           (io_req_valid),
        .io_req_addr            (io_req_addr),
        .io_upper_low           (up_lo),
        .io_upper_high          (up_hi),
        .io_fwd_valid           (io_fwd_valid),
        .io_fwd_hit             (io_fwd_hit),
        .primary_bus_num        (pbn),
        .secondary_bus_num      (sbn),
        .subordinate_bus_num    (subn),
        .io_width_capability    (io_cap)
    );

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask : chk

    // one transfer: setup, then access until pready is seen high
    task automatic apb(input logic [7:0] a, input logic w,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h0000_0001);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        apb(idx << 2, 1'b0, 32'h0, 4'h0);
        chk(rd, exp);
        chk({31'h0, er}, 32'h0);
    endtask : rd_chk

    task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                      input logic [3:0] s);
        apb(idx << 2, 1'b1, d, s);
    endtask : wr

    task automatic ev_pulse(input logic [4:0] m);
        ev <= m;
        @(posedge pclk);
        ev <= 5'h00;
        @(posedge pclk);
    endtask : ev_pulse

    task automatic io_chk(input logic [31:0] a, input logic exp);
        io_req_valid <= 1'b1;
        io_req_addr  <= a;
        @(posedge pclk);
        io_req_valid <= 1'b0;
        @(posedge pclk);
        chk({30'h0, io_fwd_valid, io_fwd_hit}, {30'h0, 1'b1, exp});
    endtask : io_chk

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
        perr_en = 1'b0;
        serr_en = 1'b0;
        ev = 5'h00;
        io_req_valid = 1'b0;
        io_req_addr = 32'h0;
        up_lo = 16'h0000;
        up_hi = 16'h0000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk({pbn, sbn, subn, 7'h00, io_cap}, 32'h0000_0001);
        for (int i = 0; i < 11; i++)
            rd_chk(idx_t[i], rst_v[i]);
        for (int i = 0; i < 5; i++)
        begin
            wr(idx_t[ro_i[i]], 32'hFFFF_FFFF, 4'hF);
            rd_chk(idx_t[ro_i[i]], rst_v[ro_i[i]]);
        end
        wr(IDX_PRIMARY_BUS, 32'hFFFF_FF5A, 4'hF);
        wr(IDX_SECOND_BUS, 32'h0000_00A5, 4'hF);
        wr(IDX_SUBORD_BUS, 32'h0000_00FF, 4'hF);
        wr(IDX_PRIMARY_BUS, 32'h0000_0011, 4'hE);
        rd_chk(IDX_PRIMARY_BUS, 32'h0000_005A);
        rd_chk(IDX_SECOND_BUS, 32'h0000_00A5);
        rd_chk(IDX_SUBORD_BUS, 32'h0000_00FF);
        chk({8'h00, pbn, sbn, subn}, 32'h005A_A5FF);
        // 16-bit mode, window 0x2000 to 0x3FFF
        wr(IDX_IO_BASE, 32'h0000_002E, 4'h1);
        rd_chk(IDX_IO_BASE, 32'h0000_0020);
        rd_chk(IDX_IO_LIMIT, 32'h0000_0000);
        wr(IDX_IO_LIMIT, 32'h0000_003F, 4'h1);
        rd_chk(IDX_IO_LIMIT, 32'h0000_0030);
        chk({31'h0, io_cap}, 32'h0);
        io_chk(32'h0000_1FFF, 1'b0);
        io_chk(32'h0000_2000, 1'b1);
        io_chk(32'h0000_3FFF, 1'b1);
        io_chk(32'h0000_4000, 1'b0);
        io_chk(32'h0001_2000, 1'b0);
        // 32-bit mode with upper halves 0x0001
        wr(IDX_IO_BASE, 32'h0000_0021, 4'h1);
        rd_chk(IDX_IO_LIMIT, 32'h0000_0031);
        up_lo <= 16'h0001;
        up_hi <= 16'h0001;
        io_chk(32'h0001_2000, 1'b1);
        io_chk(32'h0001_3FFF, 1'b1);
        io_chk(32'h0000_2000, 1'b0);
        io_chk(32'h0001_4000, 1'b0);
        // status events with both enables off, then with each turned on
        ev_pulse(5'b00111);
        rd_chk(IDX_SEC_STATUS, 32'h0);
        ev_pulse(5'b01000);
        rd_chk(IDX_SEC_STATUS, 32'h0000_8000);
        wr(IDX_SEC_STATUS, 32'h0000_FFFF, 4'h1);
        wr(IDX_SEC_STATUS, 32'h0000_0000, 4'h2);
        rd_chk(IDX_SEC_STATUS, 32'h0000_8000);
        wr(IDX_SEC_STATUS, 32'h0000_FFFF, 4'h3);
        rd_chk(IDX_SEC_STATUS, 32'h0);
        perr_en <= 1'b1;
        ev_pulse(5'b00001);
        rd_chk(IDX_SEC_STATUS, 32'h0000_0100);
        wr(IDX_SEC_STATUS, 32'h0000_0100, 4'h2);
        rd_chk(IDX_SEC_STATUS, 32'h0);
        ev_pulse(5'b00010);
        rd_chk(IDX_SEC_STATUS, 32'h0000_0100);
        wr(IDX_SEC_STATUS, 32'h0000_0100, 4'h2);
        serr_en <= 1'b1;
        ev_pulse(5'b00100);
        rd_chk(IDX_SEC_STATUS, 32'h0000_4000);
        ev_pulse(5'b10000);
        rd_chk(IDX_SEC_STATUS, 32'h0000_C000);
        wr(IDX_SEC_STATUS, 32'h0000_4000, 4'h2);
        rd_chk(IDX_SEC_STATUS, 32'h0000_8000);
        // unmapped words answer with an error and read zero
        apb(8'h00, 1'b0, 32'h0, 4'h0);
        chk({rd[31:1], er}, 32'h0000_0001);
        apb(8'h7C, 1'b1, 32'hFFFF_FFFF, 4'hF);
        chk({31'h0, er}, 32'h0000_0001);
        stop_test();
    end
endmodule : bridge_type1_header_regs_tb
`default_nettype wire
